/* logic/drive_profile_mapper.sv */
// drive profile assembly mapper with wishbone register access
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "drive_profile_consts.svh"

module drive_profile_mapper
  import drive_profile_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic inv_wr_o,
  output logic [15:0] inv_addr_o,
  output logic [15:0] inv_data_o,
  input wire logic inv_ack_i,
  input wire logic [15:0] inv_status_i,
  input wire logic [15:0] speed_actual_i,
  input wire logic [7:0] drive_state_i,
  input wire logic ready_i,
  input wire logic command_source_flag_i,
  input wire logic speed_source_flag_i,
  input wire logic at_speed_flag_i,
  input wire logic [15:0] speed_display_param_i,
  input wire logic [15:0] pole_setting_param_i,
  output logic [31:0] in_asm_o
);

  mapper_state_s q;
  mapper_state_s d;

  // returns {convert, poles} for the boot parameters
  function automatic logic [4:0] scaling(input logic [15:0] disp, input logic [15:0] pole);
    logic low;
    logic high;
    scaling = 5'h00;
    low = (pole >= 16'h0002) && (pole <= 16'h000A);
    high = (pole >= 16'h0066) && (pole <= 16'h006E);
    if (pole == 16'h0000 && disp <= `DISP_MAX)
    begin
      scaling = {1'b1, `DEFAULT_POLES};
    end
    else if (disp == 16'h0000 && low)
    begin
      scaling = {1'b1, pole[3:0]};
    end
    else if (disp != 16'h0000 && disp <= `DISP_MAX && high)
    begin
      scaling = {1'b1, 4'(pole - 16'h0064)};
    end
  endfunction

  function automatic logic [15:0] freq_cmd(input logic conv, input logic [3:0] poles,
                                           input logic [15:0] rpm);
    logic [19:0] prod;
    prod = 20'(rpm) * 20'(poles);
    if (conv)
    begin
      freq_cmd = 16'(prod / `HZ_DIVISOR);
    end
    else
    begin
      freq_cmd = rpm;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  logic req;
  logic wr_out;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [7:0] byte0;
  logic [15:0] run_word;
  logic modes_equal;

  assign req = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr_out = req && wb_we_i && (wb_adr_i == `ADR_OUT_ASM);
  assign byte0 = q.out_asm[7:0];
  assign modes_equal = byte0[`OUT_CMD_SRC] == byte0[`OUT_SPD_SRC];

  always_comb
  begin
    run_word = 16'h0000;
    run_word[`RUN_FWD_BIT] = byte0[`OUT_FWD];
    run_word[`RUN_REV_BIT] = q.inst21 && byte0[`OUT_REV];
  end

  always_comb
  begin
    d = q;
    ev = 4'h0;
    clr = 4'h0;
    // boot sampling of the scaling parameters, first edge after reset release
    if (!q.boot_done)
    begin
      d.boot_done = 1'b1;
      {d.conv, d.poles} = scaling(speed_display_param_i, pole_setting_param_i);
    end

    // input assembly built from inverter status
    d.in_asm = 32'h0000_0000;
    d.in_asm[0] = inv_status_i[`ST_ALARM];
    d.in_asm[1] = 1'b0;
    d.in_asm[2] = inv_status_i[`ST_RUNNING] && inv_status_i[`ST_FORWARD];
    d.in_asm[31:16] = speed_actual_i;
    if (q.inst21_cfg)
    begin
      d.in_asm[3] = inv_status_i[`ST_RUNNING] && inv_status_i[`ST_REVERSE];
      d.in_asm[4] = ready_i;
      d.in_asm[5] = command_source_flag_i;
      d.in_asm[6] = speed_source_flag_i;
      d.in_asm[7] = at_speed_flag_i;
      d.in_asm[15:8] = drive_state_i;
    end
    d.alarm_prev = inv_status_i[`ST_ALARM];
    ev[`EV_FAULT] = inv_status_i[`ST_ALARM] && !q.alarm_prev;

    // inverter write sequencer, one register write per handshake
    case (q.fsm)
      WR_IDLE:
      begin
        if (wr_out)
        begin
          d.out_asm = merge(q.out_asm, wb_dat_i, wb_sel_i);
          d.inst21 = q.inst21_cfg;
          d.fclr_edge = d.out_asm[`OUT_FCLR] && !q.fclr_prev;
          d.fclr_prev = d.out_asm[`OUT_FCLR];
          d.fsm = WR_RUN;
        end
      end
      WR_RUN:
      begin
        d.inv = '{wr: 1'b1, addr: `INV_REG_RUN, data: run_word};
        if (q.inv.wr && inv_ack_i)
        begin
          d.inv.wr = 1'b0;
          if (q.fclr_edge)
          begin
            d.fsm = WR_RESET;
          end
          else if (q.inst21 && modes_equal)
          begin
            d.fsm = WR_MODE;
          end
          else
          begin
            d.fsm = WR_FREQ;
          end
        end
      end
      WR_RESET:
      begin
        d.inv = '{wr: 1'b1, addr: `INV_REG_RESET, data: `RESET_WR_VALUE};
        if (q.inv.wr && inv_ack_i)
        begin
          d.inv.wr = 1'b0;
          ev[`EV_RESET] = 1'b1;
          d.fsm = (q.inst21 && modes_equal) ? WR_MODE : WR_FREQ;
        end
      end
      WR_MODE:
      begin
        d.inv.wr = 1'b1;
        d.inv.addr = `INV_REG_MODE;
        d.inv.data = byte0[`OUT_CMD_SRC] ? `MODE_NET : `MODE_EXT;
        if (q.inv.wr && inv_ack_i)
        begin
          d.inv.wr = 1'b0;
          d.fsm = WR_FREQ;
        end
      end
      WR_FREQ:
      begin
        d.inv.wr = 1'b1;
        d.inv.addr = `INV_REG_FREQ;
        d.inv.data = freq_cmd(q.conv, q.poles, q.out_asm[31:16]);
        if (q.inv.wr && inv_ack_i)
        begin
          d.inv.wr = 1'b0;
          ev[`EV_DONE] = 1'b1;
          d.fsm = WR_IDLE;
        end
      end
      default:
      begin
        d.fsm = WR_IDLE;
        d.inv.wr = 1'b0;
      end
    endcase
    if (wr_out && q.fsm != WR_IDLE)
    begin
      ev[`EV_OVERRUN] = 1'b1;
    end

    // wishbone slave, answer one cycle after the request
    d.ack = req;
    d.rdata = 32'h0000_0000;
    if (req && wb_we_i)
    begin
      case (wb_adr_i)
        `ADR_CTRL:
        begin
          if (wb_sel_i[0])
          begin
            d.inst21_cfg = wb_dat_i[0];
          end
        end
        `ADR_IRQ_CLR:
        begin
          clr = wb_dat_i[3:0];
        end
        `ADR_IRQ_EN:
        begin
          if (wb_sel_i[0])
          begin
            d.irq_en = wb_dat_i[3:0];
          end
        end
        default:
        begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end
    else if (req)
    begin
      case (wb_adr_i)
        `ADR_OUT_ASM: d.rdata = q.out_asm;
        `ADR_CTRL: d.rdata = {31'h0, q.inst21_cfg};
        `ADR_IN_ASM: d.rdata = q.in_asm;
        `ADR_STATE: d.rdata = {24'h0, q.conv, q.poles, q.fsm};
        `ADR_IRQ_STAT: d.rdata = {28'h0, q.irq_stat};
        `ADR_IRQ_EN: d.rdata = {28'h0, q.irq_en};
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    // sticky events, a set in the clearing cycle wins
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq = |(d.irq_stat & d.irq_en);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '{fsm: WR_IDLE, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign irq_o = q.irq;
  assign inv_wr_o = q.inv.wr;
  assign inv_addr_o = q.inv.addr;
  assign inv_data_o = q.inv.data;
  assign in_asm_o = q.in_asm;

  property p_run_fwd;
    @(posedge clk_i) disable iff (rst_i)
    inv_wr_o && inv_addr_o == `INV_REG_RUN |-> inv_data_o[1] == q.out_asm[0];
  endproperty
  a_run_fwd: assert property (p_run_fwd) else $error("forward bit of register 9 wrong");

  property p_run_rev;
    @(posedge clk_i) disable iff (rst_i)
    inv_wr_o && inv_addr_o == `INV_REG_RUN |->
      inv_data_o[2] == (q.inst21 && q.out_asm[1]);
  endproperty
  a_run_rev: assert property (p_run_rev) else $error("reverse bit of register 9 wrong");

  property p_reset_edge;
    @(posedge clk_i) disable iff (rst_i)
    inv_wr_o && inv_addr_o == `INV_REG_RESET |-> q.out_asm[2] && q.fclr_edge;
  endproperty
  a_reset_edge: assert property (p_reset_edge) else $error("reset without rising clear");

  property p_mode_value;
    @(posedge clk_i) disable iff (rst_i)
    inv_wr_o && inv_addr_o == `INV_REG_MODE |-> q.out_asm[5] == q.out_asm[6] &&
      inv_data_o == (q.out_asm[5] ? `MODE_NET : `MODE_EXT);
  endproperty
  a_mode_value: assert property (p_mode_value) else $error("mode write wrong");

  property p_freq_pass;
    @(posedge clk_i) disable iff (rst_i)
    inv_wr_o && inv_addr_o == `INV_REG_FREQ && !q.conv |-> inv_data_o == q.out_asm[31:16];
  endproperty
  a_freq_pass: assert property (p_freq_pass) else $error("speed not passed through");

  property p_freq_conv;
    @(posedge clk_i) disable iff (rst_i)
    inv_wr_o && inv_addr_o == `INV_REG_FREQ && q.conv |->
      20'(inv_data_o) * 20'd120 <= 20'(q.out_asm[31:16]) * 20'(q.poles) &&
      (20'(inv_data_o) + 20'd1) * 20'd120 > 20'(q.out_asm[31:16]) * 20'(q.poles);
  endproperty
  a_freq_conv: assert property (p_freq_conv) else $error("converted speed wrong");

  property p_boot_hold;
    @(posedge clk_i) disable iff (rst_i)
    q.boot_done && $past(q.boot_done) |-> $stable(q.conv) && $stable(q.poles);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("scaling changed after boot");

  property p_faulted;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> in_asm_o[0] == $past(inv_status_i[15]) && in_asm_o[1] == 1'b0;
  endproperty
  a_faulted: assert property (p_faulted) else $error("faulted or warning bit wrong");

  property p_fwd_running;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> in_asm_o[2] == ($past(inv_status_i[0]) && $past(inv_status_i[1]));
  endproperty
  a_fwd_running: assert property (p_fwd_running) else $error("forward running wrong");

  property p_mode_gate;
    @(posedge clk_i) disable iff (rst_i)
    inv_wr_o && inv_addr_o == `INV_REG_MODE |-> q.inst21;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("mode write for assembly 20");

  property p_in70_layout;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(q.inst21_cfg) |->
      in_asm_o[15:3] == 13'h0000 && in_asm_o[31:16] == $past(speed_actual_i);
  endproperty
  a_in70_layout: assert property (p_in70_layout) else $error("assembly 70 layout wrong");

  property p_in71_layout;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(q.inst21_cfg) |->
      in_asm_o[15:3] == {$past(drive_state_i), $past(at_speed_flag_i),
      $past(speed_source_flag_i), $past(command_source_flag_i), $past(ready_i),
      $past(inv_status_i[0]) && $past(inv_status_i[2])};
  endproperty
  a_in71_layout: assert property (p_in71_layout) else $error("assembly 71 layout wrong");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

endmodule // drive_profile_mapper

/* logic/drive_profile_consts.svh */
// constants for the drive profile assembly mapper
`ifndef DRIVE_PROFILE_CONSTS_SVH
`define DRIVE_PROFILE_CONSTS_SVH
// wishbone byte offsets
`define ADR_OUT_ASM 8'h00
`define ADR_CTRL 8'h04
`define ADR_IN_ASM 8'h08
`define ADR_STATE 8'h0C
`define ADR_IRQ_STAT 8'h10
`define ADR_IRQ_CLR 8'h14
`define ADR_IRQ_EN 8'h18
// inverter register numbers
`define INV_REG_RESET 16'h0002
`define INV_REG_RUN 16'h0009
`define INV_REG_MODE 16'h000A
`define INV_REG_FREQ 16'h000E
// register 9 bit positions
`define RUN_FWD_BIT 1
`define RUN_REV_BIT 2
// operation mode values and the reset register write value
`define MODE_EXT 16'h0010
`define MODE_NET 16'h0014
`define RESET_WR_VALUE 16'h0000
// output assembly byte 0 bit positions
`define OUT_FWD 0
`define OUT_REV 1
`define OUT_FCLR 2
`define OUT_CMD_SRC 5
`define OUT_SPD_SRC 6
// status word bit positions
`define ST_RUNNING 0
`define ST_FORWARD 1
`define ST_REVERSE 2
`define ST_ALARM 15
// scaling
`define DEFAULT_POLES 4'h4
`define HZ_DIVISOR 20'h00078
`define DISP_MAX 16'h270E
// interrupt event positions
`define EV_DONE 0
`define EV_RESET 1
`define EV_FAULT 2
`define EV_OVERRUN 3
`endif

/* logic/drive_profile_pkg.sv */
// types for the drive profile assembly mapper
package drive_profile_pkg;
  typedef enum logic [2:0] {
    WR_IDLE = 3'b000,
    WR_RUN = 3'b001,
    WR_RESET = 3'b011,
    WR_MODE = 3'b010,
    WR_FREQ = 3'b110
  } wr_state_e;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [15:0] data;
  } inv_wr_s;

  typedef struct packed {
    wr_state_e fsm;
    logic [31:0] out_asm;
    logic inst21;
    logic inst21_cfg;
    logic fclr_prev;
    logic fclr_edge;
    logic boot_done;
    logic conv;
    logic [3:0] poles;
    inv_wr_s inv;
    logic ack;
    logic [31:0] rdata;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic irq;
    logic [31:0] in_asm;
    logic alarm_prev;
  } mapper_state_s;
endpackage

/* tb/inv_model.sv */
// inverter register write responder that logs every accepted write
`timescale 1ns/1ps
module inv_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic [3:0] delay_i,
  output logic ack_o
);
  logic [3:0] wait_q;
  logic [31:0] log_q[$];

  // ack after delay_i idle cycles, one cycle wide
  always @(posedge clk_i)
  begin
    if (rst_i || !wr_i || ack_o)
    begin
      ack_o <= 1'b0;
      wait_q <= 4'h0;
    end
    else if (wait_q >= delay_i)
    begin
      ack_o <= 1'b1;
      log_q.push_back({addr_i, data_i});
    end
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule // inv_model

/* tb/tb.sv */
// self-checking bench for the drive profile assembly mapper
`timescale 1ns/1ps
`include "drive_profile_consts.svh"
module tb;
  import drive_profile_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ready = 1'b0;
  logic cmd_f = 1'b0, spd_f = 1'b0, at_f = 1'b0;
  logic ack, irq, inv_wr, inv_ack;
  logic [7:0] adr = 8'h00, dstate = 8'h00;
  logic [3:0] delay = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, in_asm;
  logic [15:0] inv_addr, inv_data;
  logic [15:0] status = 16'h0, spd_act = 16'h0, disp_p = 16'h0, pole_p = 16'h0;
  int failures = 0;
  int checks = 0;

  always #5 clk_i = ~clk_i;

  drive_profile_mapper DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .inv_wr_o(inv_wr), .inv_addr_o(inv_addr),
    .inv_data_o(inv_data), .inv_ack_i(inv_ack), .inv_status_i(status),
    .speed_actual_i(spd_act), .drive_state_i(dstate), .ready_i(ready),
    .command_source_flag_i(cmd_f), .speed_source_flag_i(spd_f), .at_speed_flag_i(at_f),
    .speed_display_param_i(disp_p), .pole_setting_param_i(pole_p), .in_asm_o(in_asm));

  inv_model u_inv (.clk_i(clk_i), .rst_i(rst_i), .wr_i(inv_wr), .addr_i(inv_addr),
    .data_i(inv_data), .delay_i(delay), .ack_o(inv_ack));

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    failures++;
    $display("[ERR] %s expected response seen none", what);
    report_and_stop();
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk_i);
    if (ack !== 1'b1)
      give_up("wb ack");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // params are held across the first edge after release
  task automatic boot(input logic [15:0] disp, input logic [15:0] pole);
    logic [31:0] q;
    disp_p <= disp;
    pole_p <= pole;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, `ADR_IRQ_EN, 32'h1, q);
    wb(1'b1, `ADR_CTRL, 32'h1, q);
  endtask

  task automatic consume(input logic [31:0] asm, input logic [31:0] exp[$]);
    logic [31:0] q;
    int n;
    u_inv.log_q.delete();
    wb(1'b1, `ADR_OUT_ASM, asm, q);
    for (n = 0; n < 300 && irq !== 1'b1; n++)
      @(posedge clk_i);
    if (irq !== 1'b1)
      give_up("sequence done irq");
    wb(1'b1, `ADR_IRQ_CLR, 32'h1, q);
    chk("write count", exp.size(), u_inv.log_q.size());
    foreach (exp[i])
      chk("inverter write", exp[i], u_inv.log_q[i]);
  endtask

  function automatic logic [15:0] hz(input logic [15:0] rpm, input int poles);
    return (poles == 0) ? rpm : 16'(int'(rpm) * poles / 120);
  endfunction

  task automatic s_commands();
    logic [31:0] q;
    consume(32'h0707_0065,
      '{32'h9_0002, 32'h2_0000, 32'hA_0014, {16'hE, hz(1799, 4)}});
    repeat (2) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(1'b0, `ADR_IRQ_STAT, 32'h0, q);
    chk("irq status", 32'h2, q);
    delay <= 4'h3;
    consume(32'h0707_0006, '{32'h9_0004, 32'hA_0010, {16'hE, hz(1799, 4)}});
    delay <= 4'h0;
    consume(32'h0078_0020, '{32'h9_0000, 32'hE_0004});
    wb(1'b1, `ADR_CTRL, 32'h0, q);
    consume(32'h0000_0067, '{32'h9_0002, 32'h2_0000, 32'hE_0000});
    wb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped read", 32'h0, q);
  endtask

  task automatic s_boot_hold();
    disp_p <= 16'h0005;
    pole_p <= 16'h0008;
    repeat (2) @(posedge clk_i);
    consume(32'h03E8_0001, '{32'h9_0002, {16'hE, hz(1000, 4)}});
  endtask

  // overrun while busy, alarm event and register read-back
  task automatic s_events();
    logic [31:0] q;
    int n;
    wb(1'b1, `ADR_IRQ_CLR, 32'hF, q);
    wb(1'b1, `ADR_IRQ_EN, 32'hC, q);
    delay <= 4'h8;
    wb(1'b1, `ADR_OUT_ASM, 32'h0010_0001, q);
    wb(1'b1, `ADR_OUT_ASM, 32'h0020_0000, q);
    status <= 16'h8000;
    wb(1'b0, `ADR_OUT_ASM, 32'h0, q);
    chk("busy write ignored", 32'h0010_0001, q);
    wb(1'b0, `ADR_STATE, 32'h0, q);
    chk("boot scaling", 32'h14, q >> 3);
    wb(1'b0, `ADR_IRQ_EN, 32'h0, q);
    chk("irq enable", 32'hC, q);
    chk("event irq", 32'h1, {31'h0, irq});
    for (n = 0; n < 50 && q[0] !== 1'b1; n++)
      wb(1'b0, `ADR_IRQ_STAT, 32'h0, q);
    if (q[0] !== 1'b1)
      give_up("sequence done status");
    chk("irq status", 32'hD, q);
    wb(1'b1, `ADR_IRQ_CLR, 32'hF, q);
    wb(1'b1, `ADR_IRQ_EN, 32'h1, q);
    status <= 16'h0000;
    delay <= 4'h0;
  endtask

  task automatic s_boot_table();
    logic [15:0] dp[7] = '{16'd0, 16'd0, 16'd5, 16'd5, 16'd5, 16'd9998, 16'd9999};
    logic [15:0] pp[7] = '{16'd6, 16'd104, 16'd0, 16'd8, 16'd108, 16'd110, 16'd0};
    int np[7] = '{6, 0, 4, 0, 8, 10, 0};
    foreach (dp[i])
    begin
      boot(dp[i], pp[i]);
      consume(32'h03E8_0001,
        '{32'h9_0002, 32'hA_0010, {16'hE, hz(1000, np[i])}});
    end
  endtask

  task automatic s_inputs();
    logic [15:0] st[3] = '{16'h8003, 16'h0005, 16'h0002};
    logic [31:0] q;
    logic [31:0] want;
    logic [7:0] b0;
    for (int c = 0; c < 2; c++)
    begin
      wb(1'b1, `ADR_CTRL, 32'(c), q);
      foreach (st[i])
      begin
        status <= st[i];
        {at_f, spd_f, cmd_f} <= 3'(i + 3);
        ready <= i[0];
        dstate <= 8'(8'h30 + i);
        spd_act <= 16'h1234 + 16'(i);
        repeat (2) @(posedge clk_i);
        b0 = {at_f, spd_f, cmd_f, ready, st[i][0] & st[i][2], st[i][0] & st[i][1], 1'b0,
          st[i][15]};
        if (c == 0)
          b0 = b0 & 8'h05;
        want = {spd_act, (c == 1) ? dstate : 8'h00, b0};
        chk("input assembly", want, in_asm);
      end
      wb(1'b0, `ADR_IN_ASM, 32'h0, q);
      chk("input assembly read", want, q);
    end
  endtask

  initial
  begin
    boot(16'h0, 16'h0);
    s_commands();
    s_boot_hold();
    s_events();
    s_inputs();
    s_boot_table();
    report_and_stop();
  end
endmodule // tb
